// ### logic/mcu_interrupt_prioritizer.sv
// interrupt prioritiser with apb control registers
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "irq_prio_defines.svh"
module mcu_interrupt_prioritizer
   import irq_prio_pkg::*;
#(
   parameter bit WIRED_OR_FITTED = 1'b1
) (
   input  wire logic                      clk_sys,
   input  wire logic                      nrst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      irq_pin_n,
   input  wire logic [`NUM_WIRED_OR-1:0]  wired_or_request,
   input  wire logic                      mask_bit,
   input  wire logic                      instr_boundary,
   input  wire logic                      software_trap,
   input  wire logic                      reset_pending,
   input  wire logic                      service_ack,
   input  wire periph_req_t               periph_req,
   input  wire can_cause_t                can_cause,
   output cpu_req_t                       cpu_req,
   output logic                           stop_wake
);
   logic [7:0]  misc;
   logic [7:0]  next_misc;
   logic        wired_or_enable;
   logic        next_wired_or_enable;
   logic [3:0]  can_ctrl;
   logic [3:0]  next_can_ctrl;
   logic        ext_latch;
   logic        next_ext_latch;
   logic        trap_latched;
   logic        next_trap_latched;
   logic        held_pending;
   logic        next_held_pending;
   logic        combined_prev;
   logic        next_combined_prev;
   logic [7:0]  pend_snap;
   logic [7:0]  next_pend_snap;
   cpu_req_t    next_cpu_req;
   logic [31:0] next_prdata;

   logic        wr_en;
   logic        rd_en;
   logic        edge_select_high;
   logic        edge_select_low;
   logic        ext_request_enable;
   logic [`NUM_WIRED_OR-1:0] wo_active;
   logic        combined_external_request;
   logic        rise;
   logic        fall;
   logic        edge_hit;
   logic        level_hit;
   logic        opt_change;
   logic        ext_pending;
   logic        can_ctrl_request;
   logic [4:0]  can_irq_reg;
   logic [7:0]  pend;
   logic        ext_served;
   logic        trap_defer;

   function automatic logic [13:0] vec_of(input logic [2:0] idx);
      case (idx)
         3'h0:    vec_of = `VEC_RESET;
         3'h1:    vec_of = `VEC_TRAP;
         3'h2:    vec_of = `VEC_EXT;
         3'h3:    vec_of = `VEC_CAPTURE;
         3'h4:    vec_of = `VEC_COMPARE;
         3'h5:    vec_of = `VEC_OVERFLOW;
         3'h6:    vec_of = `VEC_SERIAL;
         default: vec_of = `VEC_CAN;
      endcase
   endfunction

   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~penable & ~pwrite;
   assign pslverr = psel & penable & ~((paddr == `MISC_CONTROL_ADDR) || (paddr == `SOURCE_REG_ADDR)
                    || (paddr == `CAN_STATUS_ADDR) || (paddr == `CAN_CONTROL_ADDR));

   assign edge_select_high   = misc[`MISC_BIT_EDGE_HIGH];
   assign edge_select_low    = misc[`MISC_BIT_EDGE_LOW];
   assign ext_request_enable = misc[`MISC_BIT_EXT_EN];

   // wired-or inputs gated by enable and option
   genvar g;
   generate
      for (g = 0; g < `NUM_WIRED_OR; g++) begin : g_wo
         assign wo_active[g] = wired_or_request[g] & wired_or_enable & WIRED_OR_FITTED;
      end
   endgenerate

   // or-ed before sensitivity; a high wired-or holds the or high, hiding other edges
   assign combined_external_request = (|wo_active) | ~irq_pin_n;
   assign rise = combined_external_request & ~combined_prev;
   assign fall = ~combined_external_request & combined_prev;

   // pin polarity is inverted in the or; pin falling edge is or rising edge
   always_comb begin
      edge_hit  = 1'b0;
      level_hit = 1'b0;
      case ({edge_select_high, edge_select_low})
         2'b00: begin
            edge_hit  = rise;
            level_hit = combined_external_request;
         end
         2'b01: edge_hit = rise;
         2'b10: edge_hit = fall;
         default: edge_hit = rise | fall;
      endcase
   end

   assign stop_wake = |wo_active;

   assign can_irq_reg      = {can_cause.wakeup, can_cause.overrun, can_cause.error,
                              can_cause.transmitted, can_cause.received};
   assign can_ctrl_request = can_cause.wakeup | (|(can_irq_reg[3:0] & can_ctrl));

   assign ext_pending = ext_request_enable & (ext_latch | level_hit);
   assign pend = {can_ctrl_request & ~mask_bit,
                  periph_req.serial & ~mask_bit,
                  periph_req.overflow & ~mask_bit,
                  periph_req.compare & ~mask_bit,
                  periph_req.capture & ~mask_bit,
                  ext_pending & ~mask_bit,
                  trap_latched,
                  reset_pending};

   assign ext_served = service_ack & cpu_req.request & (cpu_req.index == 3'(SRC_EXT));
   assign trap_defer = held_pending & (|(pend_snap[7:2] & pend[7:2]));

   // misc writes gated by mask bit
   always_comb begin
      next_misc            = misc;
      next_wired_or_enable = wired_or_enable;
      next_can_ctrl        = can_ctrl;
      opt_change           = 1'b0;
      if (wr_en && (paddr == `MISC_CONTROL_ADDR)) begin
         if (mask_bit) begin
            next_misc[`MISC_BIT_EDGE_HIGH] = pwdata[`MISC_BIT_EDGE_HIGH];
            next_misc[`MISC_BIT_EDGE_LOW]  = pwdata[`MISC_BIT_EDGE_LOW];
            next_misc[`MISC_BIT_EXT_EN]    = pwdata[`MISC_BIT_EXT_EN];
            opt_change = (pwdata[`MISC_BIT_EDGE_HIGH] != edge_select_high)
                         || (pwdata[`MISC_BIT_EDGE_LOW] != edge_select_low);
         end
      end else if (wr_en && (paddr == `SOURCE_REG_ADDR)) begin
         next_wired_or_enable = pwdata[0];
      end else if (wr_en && (paddr == `CAN_CONTROL_ADDR)) begin
         next_can_ctrl = pwdata[3:0];
      end
   end

   // external latch: edge set wins over service clear, option change discards
   always_comb begin
      next_ext_latch     = ext_latch;
      next_combined_prev = combined_external_request;
      if (opt_change) begin
         next_ext_latch = 1'b0;
      end else if (edge_hit) begin
         next_ext_latch = 1'b1;
      end else if (ext_served) begin
         next_ext_latch = 1'b0;
      end
   end

   // trap ordering and boundary arbitration
   always_comb begin
      next_trap_latched = trap_latched;
      next_held_pending = held_pending;
      next_pend_snap    = pend_snap;
      next_cpu_req      = cpu_req;
      if (instr_boundary) begin
         next_cpu_req.request = |pend;
         next_cpu_req.index   = 3'(SRC_CAN);
         for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
            // while deferred only reset and sources pending at the trap fetch compete
            if (pend[i] && (!trap_defer || i == 0 || (i > 1 && pend_snap[i]))) begin
               next_cpu_req.index = 3'(i);
            end
         end
         if (held_pending && !trap_defer) begin
            next_held_pending = 1'b0;
         end
         next_cpu_req.vector = vec_of(next_cpu_req.index);
      end
      if (service_ack && cpu_req.request) begin
         next_cpu_req.request = 1'b0;
         if (cpu_req.index == 3'(SRC_TRAP)) begin
            next_trap_latched = 1'b0;
            next_held_pending = 1'b0;
         end
         if (cpu_req.index != 3'(SRC_TRAP) && held_pending) begin
            next_pend_snap[cpu_req.index] = 1'b0;
         end
      end
      // a trap fetched in the cycle of an ack still sets the latch
      if (software_trap) begin
         next_trap_latched = 1'b1;
         next_held_pending = |pend[7:2];
         next_pend_snap    = pend;
      end
   end

   always_comb begin
      next_prdata = prdata;
      if (rd_en) begin
         if (paddr == `MISC_CONTROL_ADDR) begin
            next_prdata = {24'h0, 1'b0, edge_select_high, edge_select_low, ext_request_enable, 4'h0};
         end else if (paddr == `SOURCE_REG_ADDR) begin
            next_prdata = {16'h0, pend, 7'h0, wired_or_enable};
         end else if (paddr == `CAN_STATUS_ADDR) begin
            next_prdata = {27'h0, can_irq_reg};
         end else if (paddr == `CAN_CONTROL_ADDR) begin
            next_prdata = {28'h0, can_ctrl};
         end else begin
            next_prdata = 32'h0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         misc            <= `MISC_RESET_VALUE;
         wired_or_enable <= `WIRED_OR_EN_RESET;
         can_ctrl        <= `CAN_CTRL_RESET;
         ext_latch       <= 1'b0;
         trap_latched    <= 1'b0;
         held_pending    <= 1'b0;
         combined_prev   <= 1'b0;
         pend_snap       <= 8'h00;
         cpu_req         <= '0;
         prdata          <= 32'h0;
      end else begin
         misc            <= next_misc;
         wired_or_enable <= next_wired_or_enable;
         can_ctrl        <= next_can_ctrl;
         ext_latch       <= next_ext_latch;
         trap_latched    <= next_trap_latched;
         held_pending    <= next_held_pending;
         combined_prev   <= next_combined_prev;
         pend_snap       <= next_pend_snap;
         cpu_req         <= next_cpu_req;
         prdata          <= next_prdata;
      end
   end

   property p_mask_write_blocked;
      @(posedge clk_sys) disable iff (!nrst)
      (wr_en && paddr == `MISC_CONTROL_ADDR && !mask_bit) |=> $stable(misc);
   endproperty
   a_mask_write_blocked: assert property (p_mask_write_blocked) else $error("misc changed while unmasked");

   property p_ext_en_write;
      @(posedge clk_sys) disable iff (!nrst)
      (wr_en && paddr == `MISC_CONTROL_ADDR && mask_bit) |=> (misc[`MISC_BIT_EXT_EN] == $past(pwdata[4]));
   endproperty
   a_ext_en_write: assert property (p_ext_en_write) else $error("ext enable write lost");

   property p_opt_discard;
      @(posedge clk_sys) disable iff (!nrst)
      opt_change |=> !ext_latch;
   endproperty
   a_opt_discard: assert property (p_opt_discard) else $error("pending kept after option change");

   property p_edge_latch;
      @(posedge clk_sys) disable iff (!nrst)
      (edge_hit && !opt_change) |=> ext_latch;
   endproperty
   a_edge_latch: assert property (p_edge_latch) else $error("edge not latched");

   property p_masked_only_high;
      @(posedge clk_sys) disable iff (!nrst)
      (instr_boundary && mask_bit && !reset_pending) |=> (!cpu_req.request || cpu_req.index == 3'(SRC_TRAP));
   endproperty
   a_masked_only_high: assert property (p_masked_only_high) else $error("maskable served while masked");

   property p_vector_match;
      @(posedge clk_sys) disable iff (!nrst)
      cpu_req.request |-> (cpu_req.vector == (`VEC_RESET - {10'h000, cpu_req.index, 1'b0}));
   endproperty
   a_vector_match: assert property (p_vector_match) else $error("vector does not match index");

   property p_reset_first;
      @(posedge clk_sys) disable iff (!nrst)
      (instr_boundary && reset_pending) |=> (cpu_req.request && cpu_req.index == 3'(SRC_RESET));
   endproperty
   a_reset_first: assert property (p_reset_first) else $error("reset not given priority");

   property p_boundary_only;
      @(posedge clk_sys) disable iff (!nrst)
      (!instr_boundary && !(service_ack && cpu_req.request)) |=> $stable(cpu_req);
   endproperty
   a_boundary_only: assert property (p_boundary_only) else $error("request changed mid instruction");

   property p_wake;
      @(posedge clk_sys) disable iff (!nrst)
      (wired_or_enable && WIRED_OR_FITTED && |wired_or_request) |-> stop_wake;
   endproperty
   a_wake: assert property (p_wake) else $error("wired-or did not wake");

   property p_trap_taken;
      @(posedge clk_sys) disable iff (!nrst)
      (instr_boundary && trap_latched && !reset_pending && !held_pending)
         |=> (cpu_req.request && cpu_req.index == 3'(SRC_TRAP));
   endproperty
   a_trap_taken: assert property (p_trap_taken) else $error("trap not taken");

   property p_trap_defer;
      @(posedge clk_sys) disable iff (!nrst)
      (instr_boundary && trap_defer && !reset_pending) |=> (cpu_req.index != 3'(SRC_TRAP));
   endproperty
   a_trap_defer: assert property (p_trap_defer) else $error("trap overtook older request");

   property p_ext_serve_clear;
      @(posedge clk_sys) disable iff (!nrst)
      (ext_served && !edge_hit && !opt_change) |=> !ext_latch;
   endproperty
   a_ext_serve_clear: assert property (p_ext_serve_clear) else $error("latch kept after service");

   property p_level_unlatched;
      @(posedge clk_sys) disable iff (!nrst)
      (!ext_latch && !edge_hit) |=> !ext_latch;
   endproperty
   a_level_unlatched: assert property (p_level_unlatched) else $error("latch set without edge");

   property p_ext_first;
      @(posedge clk_sys) disable iff (!nrst)
      (instr_boundary && pend[2] && !reset_pending && !trap_latched)
         |=> (cpu_req.request && cpu_req.index == 3'(SRC_EXT));
   endproperty
   a_ext_first: assert property (p_ext_first) else $error("external not served");

   property p_ack_drops;
      @(posedge clk_sys) disable iff (!nrst)
      (service_ack && cpu_req.request && !instr_boundary) |=> !cpu_req.request;
   endproperty
   a_ack_drops: assert property (p_ack_drops) else $error("request kept after ack");

   property p_request_up;
      @(posedge clk_sys) disable iff (!nrst)
      (instr_boundary && !service_ack && |pend) |=> cpu_req.request;
   endproperty
   a_request_up: assert property (p_request_up) else $error("pending source not requested");
endmodule

// ### logic/irq_prio_defines.svh
// constants for the interrupt prioritiser
`ifndef IRQ_PRIO_DEFINES_SVH
`define IRQ_PRIO_DEFINES_SVH
`define MISC_CONTROL_OFFSET   12'h00c
`define SOURCE_REG_OFFSET     12'h010
`define CAN_STATUS_OFFSET     12'h023
`define CAN_CONTROL_OFFSET    12'h020
// bus byte addresses: four times the register index
`define MISC_CONTROL_ADDR     12'h030
`define SOURCE_REG_ADDR       12'h040
`define CAN_STATUS_ADDR       12'h08c
`define CAN_CONTROL_ADDR      12'h080
`define MISC_BIT_EDGE_HIGH    6
`define MISC_BIT_EDGE_LOW     5
`define MISC_BIT_EXT_EN       4
`define MISC_RESET_VALUE      8'h10
`define WIRED_OR_EN_RESET     1'b0
`define CAN_CTRL_RESET        4'h0
`define VEC_RESET             14'h3ffe
`define VEC_TRAP              14'h3ffc
`define VEC_EXT               14'h3ffa
`define VEC_CAPTURE           14'h3ff8
`define VEC_COMPARE           14'h3ff6
`define VEC_OVERFLOW          14'h3ff4
`define VEC_SERIAL            14'h3ff2
`define VEC_CAN               14'h3ff0
`define NUM_SOURCES           8
`define NUM_WIRED_OR          9
`endif

// ### logic/irq_prio_pkg.sv
// types for the interrupt prioritiser
package irq_prio_pkg;
   typedef enum logic [2:0] {
      SRC_RESET, SRC_TRAP, SRC_EXT, SRC_CAPTURE, SRC_COMPARE, SRC_OVERFLOW, SRC_SERIAL, SRC_CAN
   } src_t;
   typedef struct packed {
      logic       request;
      logic [2:0] index;
      logic [13:0] vector;
   } cpu_req_t;
   typedef struct packed {
      logic       capture;
      logic       compare;
      logic       overflow;
      logic       serial;
   } periph_req_t;
   typedef struct packed {
      logic received;
      logic transmitted;
      logic error;
      logic overrun;
      logic wakeup;
   } can_cause_t;
endpackage

// ### tb/cpu_core_model.sv
// cpu core model: instruction boundaries, vector fetch and acknowledge
`timescale 1ns/1ps
module cpu_core_model
   import irq_prio_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire logic     nrst,
   input  wire cpu_req_t cpu_req,
   output logic          instr_boundary,
   output logic          service_ack,
   output logic          taken_valid,
   output cpu_req_t      taken
);
   logic [1:0] phase;
   logic       fetch;
   assign fetch = cpu_req.request && !service_ack;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         phase          <= 2'h0;
         instr_boundary <= 1'b0;
         service_ack    <= 1'b0;
         taken_valid    <= 1'b0;
         taken          <= '0;
      end else begin
         phase          <= phase + 2'h1;
         // boundary only once the last vector has been taken
         instr_boundary <= (phase == 2'h3) && !cpu_req.request && !service_ack;
         service_ack    <= fetch;
         taken_valid    <= fetch;
         if (fetch) begin
            taken <= cpu_req;
         end
      end
   end
endmodule

// ### tb/mcu_interrupt_prioritizer_test.sv
// self-checking bench for the interrupt prioritiser
`timescale 1ns/1ps
`include "irq_prio_defines.svh"
module mcu_interrupt_prioritizer_test
   import irq_prio_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        irq_pin_n, mask_bit, software_trap, reset_pending;
   logic        instr_boundary, service_ack, stop_wake, taken_valid;
   logic [8:0]  wired_or_request;
   periph_req_t periph_req;
   can_cause_t  can_cause;
   cpu_req_t    cpu_req, taken;
   int          failures = 0;
   int          cmp_count = 0;
   int          n_taken = 0;

   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) n_taken <= n_taken + int'(taken_valid);

   mcu_interrupt_prioritizer #(.WIRED_OR_FITTED(1'b1)) u_dut (
      .clk_sys          (clk_sys),
      .nrst             (nrst),
      .psel             (psel),
      .penable          (penable),
      .pwrite           (pwrite),
      .paddr            (paddr),
      .pwdata           (pwdata),
      .prdata           (prdata),
      .pready           (pready),
      .pslverr          (pslverr),
      .irq_pin_n        (irq_pin_n),
      .wired_or_request (wired_or_request),
      .mask_bit         (mask_bit),
      .instr_boundary   (instr_boundary),
      .software_trap    (software_trap),
      .reset_pending    (reset_pending),
      .service_ack      (service_ack),
      .periph_req       (periph_req),
      .can_cause        (can_cause),
      .cpu_req          (cpu_req),
      .stop_wake        (stop_wake)
   );

   cpu_core_model u_cpu (
      .clk_sys        (clk_sys),
      .nrst           (nrst),
      .cpu_req        (cpu_req),
      .instr_boundary (instr_boundary),
      .service_ack    (service_ack),
      .taken_valid    (taken_valid),
      .taken          (taken)
   );

   task automatic test_done();
      $display("failures %0d compares %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   // waits for the cpu model to take a vector
   task automatic expect_take(input int idx);
      int t;
      t = 0;
      while (taken_valid !== 1'b1 && t < 100) begin
         @(posedge clk_sys);
         t++;
      end
      check(32'(t < 100), 32'h1);
      check(32'(taken.index), 32'(idx));
      check(32'(taken.vector), 32'(14'h3ffe - 14'(2 * idx)));
      @(posedge clk_sys);
   endtask

   task automatic quiet(input int n);
      int c;
      c = n_taken;
      repeat (n) @(posedge clk_sys);
      check(32'(n_taken), 32'(c));
   endtask

   task automatic pulse_pin();
      irq_pin_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      irq_pin_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask

   initial begin
      psel             = 1'b0;
      penable          = 1'b0;
      pwrite           = 1'b0;
      paddr            = 12'h000;
      pwdata           = 32'h0;
      irq_pin_n        = 1'b1;
      wired_or_request = 9'h000;
      mask_bit         = 1'b1;
      software_trap    = 1'b0;
      reset_pending    = 1'b0;
      periph_req       = '0;
      can_cause        = '0;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, `MISC_CONTROL_ADDR, 32'h0);
      check(rd, 32'h10);
      apb(1'b0, `SOURCE_REG_ADDR, 32'h0);
      check(rd & 32'h1, 32'h0);
      apb(1'b0, `CAN_CONTROL_ADDR, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h0fc, 32'h0);
      check(32'(err), 32'h1);
      check(rd, 32'h0);
      // all maskable sources except external at once, served one by one
      apb(1'b1, `CAN_CONTROL_ADDR, 32'h1);
      periph_req <= '1;
      can_cause  <= can_cause_t'(5'h10);
      mask_bit   <= 1'b0;
      for (int i = 3; i < 8; i++) begin
         expect_take(i);
         if (i < 7) periph_req[6 - i] <= 1'b0;
         else can_cause <= '0;
      end
      mask_bit          <= 1'b1;
      periph_req.serial <= 1'b1;
      quiet(20);
      reset_pending <= 1'b1;
      mask_bit      <= 1'b0;
      expect_take(0);
      reset_pending <= 1'b0;
      expect_take(6);
      periph_req <= '0;
      mask_bit   <= 1'b1;
      software_trap <= 1'b1;
      @(posedge clk_sys);
      software_trap <= 1'b0;
      expect_take(1);
      // option bits locked while unmasked
      mask_bit <= 1'b0;
      apb(1'b1, `MISC_CONTROL_ADDR, 32'h60);
      apb(1'b0, `MISC_CONTROL_ADDR, 32'h0);
      check(rd, 32'h10);
      mask_bit <= 1'b1;
      apb(1'b1, `MISC_CONTROL_ADDR, 32'h30);
      apb(1'b0, `MISC_CONTROL_ADDR, 32'h0);
      check(rd, 32'h30);
      pulse_pin();
      mask_bit <= 1'b0;
      expect_take(2);
      quiet(12);
      mask_bit <= 1'b1;
      apb(1'b1, `MISC_CONTROL_ADDR, 32'h20);
      pulse_pin();
      mask_bit <= 1'b0;
      quiet(12);
      mask_bit <= 1'b1;
      apb(1'b1, `MISC_CONTROL_ADDR, 32'h30);
      mask_bit <= 1'b0;
      expect_take(2);
      mask_bit <= 1'b1;
      pulse_pin();
      apb(1'b1, `MISC_CONTROL_ADDR, 32'h50);
      mask_bit <= 1'b0;
      quiet(12);
      wired_or_request[8] <= 1'b1;
      @(posedge clk_sys);
      check(32'(stop_wake), 32'h0);
      apb(1'b1, `SOURCE_REG_ADDR, 32'h1);
      check(32'(stop_wake), 32'h1);
      wired_or_request <= 9'h000;
      expect_take(2);
      // both edges, then a low level that persists
      mask_bit <= 1'b1;
      apb(1'b1, `MISC_CONTROL_ADDR, 32'h70);
      mask_bit  <= 1'b0;
      irq_pin_n <= 1'b0;
      expect_take(2);
      irq_pin_n <= 1'b1;
      expect_take(2);
      mask_bit <= 1'b1;
      apb(1'b1, `MISC_CONTROL_ADDR, 32'h10);
      mask_bit  <= 1'b0;
      irq_pin_n <= 1'b0;
      expect_take(2);
      expect_take(2);
      irq_pin_n <= 1'b1;
      quiet(12);
      // wake-up needs no enable, other causes do
      apb(1'b1, `CAN_CONTROL_ADDR, 32'h0);
      can_cause <= can_cause_t'(5'h11);
      expect_take(7);
      can_cause <= can_cause_t'(5'h10);
      apb(1'b0, `CAN_STATUS_ADDR, 32'h0);
      check(rd, 32'h1);
      quiet(12);
      can_cause <= '0;
      test_done();
   end

   initial begin
      #200000;
      failures++;
      test_done();
   end
endmodule
